/* boot_decode_defines.svh */
// Purpose: constants for the boot mode and address decode block
// Assumes: byte addresses, 32-bit requester addresses
// Notes:   definitions only
`ifndef BOOT_DECODE_DEFINES_SVH
`define BOOT_DECODE_DEFINES_SVH

`define CPU_REG_BASE      32'h4001_0000
`define HOST_REG_BASE     32'h000D_0000
`define HOST_SPACE_BYTES  32'h0020_0000
`define HOST_ADDR_BITS    21
`define IRAM_MIRROR_BYTES 32'h000C_0000
`define HSP_UPPER_BYTES   32'h0000_D000
`define EXT_MEM_BYTES     32'h1000_0000
`define EXT_CS_COUNT      4
`define RESET_EXC_NUM     8'h01
`define RESET_PRIORITY    -3
`define SYS_EXC_LAST      8'h0F
`define IRQ_EXC_FIRST     8'h10

`endif

/* boot_decode_pkg.sv */
// Purpose: types for the boot mode and address decode block
// Assumes: nothing
// Notes:   constants live in the defines header
package boot_decode_pkg;

    typedef enum logic [1:0]
    {
        BOOT_EXT_MEM   = 2'b00,
        BOOT_SER_FLASH = 2'b01,
        BOOT_EXT_HOST  = 2'b10,
        BOOT_IRAM      = 2'b11
    } boot_mode_e;

    // per-mode capabilities published to the rest of the chip
    typedef struct packed
    {
        logic host_if_enable;
        logic mirror_to_iram;
        logic mirror_reserved;
        logic debug_only;
    } boot_cfg_s;

    // reset cause sources, active high after inversion
    typedef struct packed
    {
        logic system_reset;
        logic power_on_reset;
        logic warm_reset;
        logic watchdog;
        logic core_reset_request_bit;
        logic software_reset_register;
    } reset_src_s;

endpackage : boot_decode_pkg

/* boot_mode_address_decode.sv */
// Purpose: boot mode latch, mirror window map, register base translate
// Assumes: all inputs synchronous to i_mclk
// Notes:   requester offsets are relative to the peripheral register area
`include "boot_decode_defines.svh"

module boot_mode_address_decode
(
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_n,
    // boot straps
    input  wire logic                      i_boot_select_high,
    input  wire logic                      i_boot_select_low,
    // reset sources
    input  wire logic                      i_system_reset_n,
    input  wire logic                      i_power_on_reset_n,
    input  wire logic                      i_warm_reset_n,
    input  wire logic                      i_watchdog_reset,
    input  wire logic                      i_core_reset_request_bit,
    input  wire logic                      i_software_reset_register,
    // register offset translation
    input  wire logic [15:0]               i_cpu_offset,
    input  wire logic [15:0]               i_host_offset,
    input  wire logic [31:0]               i_host_addr,
    // interrupt line to exception number
    input  wire logic [7:0]                i_irq_line,
    // decoded outputs
    output boot_decode_pkg::boot_mode_e    o_boot_mode,
    output boot_decode_pkg::boot_cfg_s     o_boot_cfg,
    output logic [31:0]                    o_cpu_reg_addr,
    output logic [31:0]                    o_host_reg_addr,
    output logic                           o_host_addr_ok,
    output logic                           o_reset_exc,
    output logic [7:0]                     o_reset_exc_num,
    output logic [7:0]                     o_irq_exc_num
);

    // ************************************************************
    // boot mode latch
    // ************************************************************
    logic                         strap_armed_reg;
    boot_decode_pkg::boot_mode_e  mode_next;

    function automatic boot_decode_pkg::boot_cfg_s cfg_of
    (
        input boot_decode_pkg::boot_mode_e m
    );
        boot_decode_pkg::boot_cfg_s c;
        c.host_if_enable  = (m != boot_decode_pkg::BOOT_EXT_MEM);
        c.mirror_to_iram  = m[1];
        c.mirror_reserved = (m == boot_decode_pkg::BOOT_SER_FLASH);
        c.debug_only      = (m == boot_decode_pkg::BOOT_IRAM);
        return c;
    endfunction : cfg_of

    always_comb
    begin
        case ({i_boot_select_high, i_boot_select_low})
            2'b00:   mode_next = boot_decode_pkg::BOOT_EXT_MEM;
            2'b01:   mode_next = boot_decode_pkg::BOOT_SER_FLASH;
            2'b10:   mode_next = boot_decode_pkg::BOOT_EXT_HOST;
            2'b11:   mode_next = boot_decode_pkg::BOOT_IRAM;
            default: mode_next = boot_decode_pkg::BOOT_EXT_MEM;
        endcase
    end

    // straps caught on the first clock after release, then frozen
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            strap_armed_reg <= 1'b1;
            o_boot_mode     <= boot_decode_pkg::BOOT_EXT_MEM;
            o_boot_cfg      <= '0;
        end
        else if (strap_armed_reg)
        begin
            strap_armed_reg <= 1'b0;
            o_boot_mode     <= mode_next;
            o_boot_cfg      <= cfg_of(mode_next);
        end
    end

    // ************************************************************
    // register base translation
    // ************************************************************
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_cpu_reg_addr  <= 32'h0000_0000;
            o_host_reg_addr <= 32'h0000_0000;
            o_host_addr_ok  <= 1'b0;
        end
        else
        begin
            o_cpu_reg_addr  <= `CPU_REG_BASE + {16'h0000, i_cpu_offset};
            o_host_reg_addr <= `HOST_REG_BASE + {16'h0000, i_host_offset};
            // host window is only 2 Mbytes and only live when enabled
            o_host_addr_ok  <= o_boot_cfg.host_if_enable
                && (i_host_addr < `HOST_SPACE_BYTES);
        end
    end

    // ************************************************************
    // reset exception and numbering
    // ************************************************************
    boot_decode_pkg::reset_src_s src;

    always_comb
    begin
        src.system_reset            = !i_system_reset_n;
        src.power_on_reset          = !i_power_on_reset_n;
        src.warm_reset              = !i_warm_reset_n;
        src.watchdog                = i_watchdog_reset;
        src.core_reset_request_bit  = i_core_reset_request_bit;
        src.software_reset_register = i_software_reset_register;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_reset_exc     <= 1'b0;
            o_reset_exc_num <= 8'h00;
            o_irq_exc_num   <= 8'h10;
        end
        else
        begin
            o_reset_exc     <= |src;
            o_reset_exc_num <= (|src) ? `RESET_EXC_NUM : 8'h00;
            o_irq_exc_num   <= `IRQ_EXC_FIRST + i_irq_line;
        end
    end

    // ************************************************************
    // memory map facts
    // ************************************************************
    // one shared copy for the decoders around this block;
    // nothing here is decoded, the floorplan fixes these spans
    localparam logic [31:0] MIRROR_SPAN  = `IRAM_MIRROR_BYTES;
    localparam logic [31:0] FAST_UPPER   = `HSP_UPPER_BYTES;
    localparam logic [31:0] EXT_MEM_SPAN = `EXT_MEM_BYTES;
    localparam int          EXT_SELECTS  = `EXT_CS_COUNT;
    localparam int          RESET_PRIO   = `RESET_PRIORITY;
    localparam logic [7:0]  SYS_EXC_TOP  = `SYS_EXC_LAST;

    // ************************************************************
    // checks
    // ************************************************************
    a_mode_held_stable: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !strap_armed_reg && !$past(strap_armed_reg)
            |-> $stable(o_boot_mode))
        else $error("boot mode changed after latch");

    a_host_off_extmem: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_boot_mode == boot_decode_pkg::BOOT_EXT_MEM |=> !o_host_addr_ok)
        else $error("host access granted in external memory boot");

    a_mirror_map_mode: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !strap_armed_reg |-> o_boot_cfg.mirror_to_iram == o_boot_mode[1]
            && o_boot_cfg.mirror_reserved
               == (o_boot_mode == boot_decode_pkg::BOOT_SER_FLASH))
        else $error("mirror window map wrong for mode");

    a_cpu_base_add: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_cpu_reg_addr == 32'h4001_0000
            + {16'h0000, $past(i_cpu_offset)})
        else $error("cpu register address wrong");

    a_host_base_add: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_host_reg_addr == 32'h000D_0000
            + {16'h0000, $past(i_host_offset)})
        else $error("host register address wrong");

    a_host_space_limit: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_host_addr >= 32'h0020_0000 |=> !o_host_addr_ok)
        else $error("host address beyond 2 Mbytes accepted");

    a_reset_exc_raise: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_warm_reset_n || i_watchdog_reset || i_software_reset_register)
            |=> o_reset_exc && o_reset_exc_num == 8'h01)
        else $error("reset exception not raised");

    a_irq_numbering: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        ##1 o_irq_exc_num >= 8'h10)
        else $error("interrupt numbered in system range");

    a_strap_capture: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        strap_armed_reg |=> o_boot_mode
            == $past({i_boot_select_high, i_boot_select_low}))
        else $error("boot mode not taken from straps at release");

    a_host_if_mode: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !strap_armed_reg |-> o_boot_cfg.host_if_enable
            == (o_boot_mode != boot_decode_pkg::BOOT_EXT_MEM))
        else $error("host interface enable wrong for mode");

    a_reset_pin_raise: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_system_reset_n || !i_power_on_reset_n
            || i_core_reset_request_bit)
            |=> o_reset_exc && o_reset_exc_num == 8'h01)
        else $error("reset exception not raised by pin or core");

    a_reset_exc_drop: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_system_reset_n && i_power_on_reset_n && i_warm_reset_n
            && !i_watchdog_reset && !i_core_reset_request_bit
            && !i_software_reset_register)
            |=> !o_reset_exc && o_reset_exc_num == 8'h00)
        else $error("reset exception raised with no source");

endmodule : boot_mode_address_decode

/* boot_mode_address_decode_tb.sv */
// Purpose: self-checking bench for boot mode and address decode
// Assumes: inputs driven on the falling edge
// Notes:   host requests pass through host_model, one extra cycle
module boot_mode_address_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_n = 1'b0, rq = 1'b0;
    logic [1:0]  sel = 2'b00;
    logic [5:0]  rsrc = 6'h00;
    logic [15:0] cpu_off = 16'h0000, req_off = 16'h0000;
    logic [31:0] req_addr = 32'h0000_0000, cpu_a, host_a;
    logic [15:0] h_off;
    logic [31:0] h_addr;
    logic [7:0]  irq = 8'h00, exc_num, irq_num;
    logic        ok, exc;
    boot_decode_pkg::boot_mode_e mode;
    boot_decode_pkg::boot_cfg_s  cfg;
    int miscompares = 0, tests_run = 0, cycles = 0;
    initial forever #4 mclk = ~mclk;
    host_model i_host (.i_mclk(mclk), .i_reg(rq), .i_offset(req_off),
        .i_addr(req_addr), .o_host_offset(h_off), .o_host_addr(h_addr));
    boot_mode_address_decode i_dut (.i_mclk(mclk), .i_rst_n(rst_n),
        .i_boot_select_high(sel[1]), .i_boot_select_low(sel[0]),
        .i_system_reset_n(~rsrc[5]), .i_power_on_reset_n(~rsrc[4]),
        .i_warm_reset_n(~rsrc[3]), .i_watchdog_reset(rsrc[2]),
        .i_core_reset_request_bit(rsrc[1]),
        .i_software_reset_register(rsrc[0]), .i_cpu_offset(cpu_off),
        .i_host_offset(h_off), .i_host_addr(h_addr), .i_irq_line(irq),
        .o_boot_mode(mode), .o_boot_cfg(cfg), .o_cpu_reg_addr(cpu_a),
        .o_host_reg_addr(host_a), .o_host_addr_ok(ok), .o_reset_exc(exc),
        .o_reset_exc_num(exc_num), .o_irq_exc_num(irq_num));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // straps valid through release, then flipped to prove they are ignored
    task automatic t_boot(input logic [1:0] m);
        @(negedge mclk);
        rst_n = 1'b0;
        sel   = m;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        sel = ~m;
        check(32'(mode), 32'(m));
        check(32'(cfg), {28'h0, m != 2'b00, m[1], m == 2'b01, m == 2'b11});
        repeat (3) @(negedge mclk);
        check(32'(mode), 32'(m));
        // host window opens one edge after the latch
        check(32'(ok), 32'(m != 2'b00));
        $display("boot mode %0d done", m);
    endtask : t_boot
    task automatic t_addr();
        cpu_off = 16'hFFFF;
        req_off = 16'h1234;
        rq = 1'b1;
        repeat (3) @(negedge mclk);
        check(cpu_a, 32'h4001_FFFF);
        check(host_a, 32'h000D_1234);
        check(32'(ok), 32'h1);
        rq = 1'b0;
        req_addr = 32'h001F_FFFF;
        repeat (3) @(negedge mclk);
        check(32'(ok), 32'h1);
        req_addr = 32'h0020_0000;
        repeat (3) @(negedge mclk);
        check(32'(ok), 32'h0);
        $display("address test done");
    endtask : t_addr
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
        begin
            rsrc = 6'h01 << i;
            @(negedge mclk);
            check({exc_num, 7'h00, exc}, 16'h0101);
            rsrc = 6'h00;
            @(negedge mclk);
            check({exc_num, 7'h00, exc}, 16'h0000);
        end
        $display("reset source test done");
    endtask : t_reset
    task automatic t_irq();
        irq = 8'h00;
        @(negedge mclk);
        check(irq_num, 8'h10);
        irq = 8'h7F;
        @(negedge mclk);
        check(irq_num, 8'h8F);
        $display("interrupt number test done");
    endtask : t_irq
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        for (int m = 0; m < 4; m++)
            t_boot(2'(m));
        t_addr();
        t_reset();
        t_irq();
        conclude();
    end
endmodule : boot_mode_address_decode_tb

/* host_model.sv */
// Purpose: external host side, issues register and window addresses
// Assumes: requests change after a falling edge of i_mclk
// Notes:   behavioural, always answers promptly
module host_model
(
    // clock
    input  wire logic        i_mclk,
    // request from the bench
    input  wire logic        i_reg,
    input  wire logic [15:0] i_offset,
    input  wire logic [31:0] i_addr,
    // host pins into the block
    output logic      [15:0] o_host_offset,
    output logic      [31:0] o_host_addr
);
    // register accesses land above the host register base
    always_ff @(posedge i_mclk)
    begin
        o_host_offset <= i_offset;
        o_host_addr   <= i_reg ? 32'h000D_0000 + {16'h0000, i_offset} : i_addr;
    end
endmodule : host_model
